/* logic/fcd_pkg.sv */
// Summary of operation
// R01 - Divided clock paces program and erase timing
// R02 - Loaded flag reads 0 until first write
// R03 - All readable; low bits write once; flag unwritable
// R04 - Prescale select divides oscillator by eight first
// R05 - Software keeps timing clock 150-200 kHz
// R06 - Total division supported up to 512
// R07 - Timing clock is osc/(8?)/(value+1)
// R08 - Security register readable, ignores all writes
// R09 - Security register loaded from nonvolatile byte
// R10 - Double fault at load sets every bit
// R11 - Backdoor enabled only for pattern 10
// R12 - Unsecured only for security pattern 10
// R13 - Backdoor unlock forces security field 10
// R14 - Reserved nonvolatile bits left erased at 1
// R15 - Pattern 01 recommended for disable and secure
`default_nettype none
package fcd_pkg;
  localparam logic [11:0] FCD_OFS_DIVIDER  = 12'h000;
  localparam logic [11:0] FCD_OFS_SECURITY = 12'h004;
  localparam logic [11:0] FCD_OFS_STATUS   = 12'h008;
  localparam logic [11:0] FCD_OFS_UNLOCK   = 12'h00C;
  localparam int FCD_LOADED_BIT   = 7;
  localparam int FCD_PRESCALE_BIT = 6;
  localparam int FCD_KEYEN_LSB    = 6;
  localparam int FCD_RNV_LSB      = 2;
  localparam int FCD_SEC_LSB      = 0;
  localparam logic [7:0] FCD_DIVIDER_RESET = 8'h00;
  localparam logic [7:0] FCD_SECURITY_RESET = 8'hFF;
  localparam logic [1:0] FCD_PATTERN_ON   = 2'h2;
  localparam logic [2:0] FCD_PRESCALE_MAX = 3'h7;
  localparam int FCD_MAX_RATIO = 512;
  localparam int FCD_OSC_HZ     = 10000000;
  localparam int FCD_TCLK_MIN_HZ = 150000;
  localparam int FCD_TCLK_MAX_HZ = 200000;
  localparam int FCD_PCLK_NS     = 100;
  typedef enum logic [1:0] {
    FCD_LD_IDLE = 2'b00,
    FCD_LD_WAIT = 2'b01,
    FCD_LD_DONE = 2'b10
  } fcd_load_t;
endpackage
`default_nettype wire

/* logic/fcd_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fcd_top (
  input  wire logic        pclk,          // Oscillator clock
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB write
  input  wire logic [11:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic             pready,        // APB ready
  output logic [31:0]      prdata,        // APB read data
  output logic             pslverr,       // APB error
  input  wire logic        nv_valid,      // Config byte fetch done
  input  wire logic [7:0]  nv_sec_byte,   // Nonvolatile security byte
  input  wire logic        double_fault_flag, // Uncorrectable fault on fetch
  input  wire logic        key_unlock,    // Backdoor key matched, pulse
  output logic             timing_tick,   // One pulse per timing period
  output logic             timing_ready,  // Divider loaded
  output logic             backdoor_enabled, // Backdoor access allowed
  output logic             secured        // Part secured
);
  import fcd_pkg::*;

  logic [7:0] timing_divider_register;
  logic [7:0] security_register;
  logic [2:0] pre_cnt;
  logic [5:0] div_cnt;
  logic       sec_loaded;
  logic       nv_s1;
  logic       nv_s2;
  logic       nv_s3;
  logic       setup_ok;
  logic [31:0] next_prdata;

  function automatic logic sel_hit(input logic [11:0] a, input logic [11:0] o);
    sel_hit = (a[11:2] == o[11:2]);
  endfunction

  wire access = psel && penable;
  wire wr     = access && pwrite;
  assign pready  = 1'b1;
  assign pslverr = access && !(sel_hit(paddr, FCD_OFS_DIVIDER)
                            || sel_hit(paddr, FCD_OFS_SECURITY)
                            || sel_hit(paddr, FCD_OFS_STATUS));
  assign setup_ok = timing_divider_register[FCD_LOADED_BIT];

  // Write-once divider; flag set only by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_divider_register <= FCD_DIVIDER_RESET;
    end else if (wr && sel_hit(paddr, FCD_OFS_DIVIDER) && !setup_ok) begin // R03
      timing_divider_register <= {1'b1, pwdata[6:0]}; // R02
    end
  end

  // Fetch-done input comes from outside; 3-stage sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_s1 <= 1'b0;
      nv_s2 <= 1'b0;
      nv_s3 <= 1'b0;
    end else begin
      nv_s1 <= nv_valid;
      nv_s2 <= nv_s1;
      nv_s3 <= nv_s2;
    end
  end

  // Secured until the config byte arrives, so early reads never show open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      security_register <= FCD_SECURITY_RESET;
      sec_loaded        <= 1'b0;
    end else if (!sec_loaded && nv_s2 && nv_s3) begin
      sec_loaded <= 1'b1;
      if (double_fault_flag) begin
        security_register <= FCD_SECURITY_RESET; // R10
      end else begin
        security_register <= nv_sec_byte; // R09
      end
    end else if (sec_loaded && key_unlock) begin
      security_register[FCD_SEC_LSB +: 2] <= FCD_PATTERN_ON; // R13
    end
  end

  // Prescaler then six-bit divider; max 8*64 = 512
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt     <= 3'h0;
      div_cnt     <= 6'h00;
      timing_tick <= 1'b0;
    end else begin
      timing_tick <= 1'b0;
      if (!setup_ok) begin
        pre_cnt <= 3'h0;
        div_cnt <= 6'h00;
      end else if (!timing_divider_register[FCD_PRESCALE_BIT]
                   || pre_cnt == FCD_PRESCALE_MAX) begin // R04
        pre_cnt <= 3'h0;
        if (div_cnt == timing_divider_register[5:0]) begin // R07 R06
          div_cnt     <= 6'h00;
          timing_tick <= 1'b1; // R01
        end else begin
          div_cnt <= div_cnt + 6'h01;
        end
      end else begin
        pre_cnt <= pre_cnt + 3'h1;
      end
    end
  end

  assign timing_ready     = setup_ok;
  assign backdoor_enabled = (security_register[FCD_KEYEN_LSB +: 2] == FCD_PATTERN_ON); // R11
  assign secured          = (security_register[FCD_SEC_LSB +: 2] != FCD_PATTERN_ON); // R12

  // Security register has no APB write path; only the config load and key unlock change it
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_hit(paddr, FCD_OFS_DIVIDER)) begin
      next_prdata = {24'h000000, timing_divider_register}; // R03
    end else if (sel_hit(paddr, FCD_OFS_SECURITY)) begin
      next_prdata = {24'h000000, security_register}; // R08
    end else if (sel_hit(paddr, FCD_OFS_STATUS)) begin
      next_prdata = {28'h0000000, sec_loaded, secured, backdoor_enabled, setup_ok};
    end
  end

  // Captured in setup phase so read data stands from a flop through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* dv/fcd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module fcd_checker (
  input wire logic        pclk,             // Clock
  input wire logic        presetn,          // Reset, active low
  input wire logic        psel,             // APB select
  input wire logic        penable,          // APB access phase
  input wire logic        pwrite,           // APB write
  input wire logic        pslverr,          // APB error
  input wire logic [11:0] paddr,            // Address
  input wire logic [31:0] prdata,           // Read data
  input wire logic        timing_tick,      // Timing pulse
  input wire logic        timing_ready,     // Divider loaded
  input wire logic        backdoor_enabled, // Backdoor allowed
  input wire logic        secured           // Part secured
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic wr0 = acc && pwrite && paddr == 12'h000;
  wire logic rd0 = acc && !pwrite && paddr == 12'h000;
  wire logic rd4 = acc && !pwrite && paddr == 12'h004;
  chk_flag_set: assert property ($rose(timing_ready) |-> $past(wr0)) else $error("flag");
  chk_flag_hold: assert property (timing_ready |=> timing_ready) else $error("flag");
  chk_flag_read: assert property (rd0 |-> prdata[7] == timing_ready) else $error("bit");
  chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("hi");
  chk_sec_map: assert property (rd4 |-> secured == (prdata[1:0] != 2'h2))
    else $error("sec");
  chk_key_map: assert property (rd4 |-> backdoor_enabled == (prdata[7:6] == 2'h2))
    else $error("key");
  chk_tick_gate: assert property (!timing_ready |-> !timing_tick) else $error("tick");
  chk_bad_addr: assert property (acc && paddr == 12'h00C |-> pslverr) else $error("err");
endmodule
bind fcd_top fcd_checker fcd_checker_inst (.*);
`default_nettype wire

/* dv/fcd_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fcd_top_tb;
  logic pclk = '0, psel = '0, penable = '0, pwrite = '0, key_unlock = '0, backdoor_enabled;
  logic presetn, nv_valid, double_fault_flag, pready, pslverr, timing_tick, timing_ready, secured;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0]  nv_sec_byte;
  int fail_count = 0, tests_run = 0;
  fcd_top fcd_top_inst (.*);
  initial forever #50 pclk = ~pclk;
  task automatic complete_run;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, y);
    tests_run++;
    if (y !== x) begin
      $display("unexpected %s expected %h seen %h", nm, x, y);
      fail_count++;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, x);
    int n = 0;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    {psel, penable} <= 2'b00;
    chk("prdata", x, n < 20 ? prdata : 32'hX);
    if (n == 20) complete_run();
  endtask
  // One full life: reset, load, unlock, divider setup, tick period
  task automatic boot(input logic [7:0] b, input logic df, input logic [7:0] v, input int per);
    int n = 0;
    logic [7:0] s;
    s = df ? 8'hFF : b;
    {presetn, nv_valid, nv_sec_byte, double_fault_flag} <= {2'b00, b, df};
    repeat (10) @(posedge pclk);
    {presetn, nv_valid} <= 2'b11;
    repeat (5) @(posedge pclk);
    xfer(0, 12'h004, 0, {24'h0, s});
    xfer(1, 12'h004, 0, 0);
    // A key match can only happen while the backdoor is enabled
    key_unlock <= (s[7:6] == 2'b10);
    @(posedge pclk) key_unlock <= 1'b0;
    if (s[7:6] == 2'b10) begin
      s[1:0] = 2'b10;
    end
    xfer(0, 12'h004, 0, {24'h0, s});
    xfer(0, 12'h000, 0, 0);
    xfer(1, 12'h000, {24'h0, v}, 0);
    xfer(1, 12'h000, 0, 0);
    xfer(0, 12'h000, 0, {24'h0, 1'b1, v[6:0]});
    xfer(0, 12'h008, 0, {28'h0, 1'b1, s[1:0] != 2'b10, s[7:6] == 2'b10, 1'b1});
    do @(posedge pclk); while (timing_tick !== 1'b1 && ++n < 600);
    if (n == 600) begin
      fail_count++;
      complete_run();
    end
    n = 0;
    do @(posedge pclk); while (timing_tick !== 1'b1 && ++n < 600);
    chk("period", per, n + 1);
    if (n == 600) complete_run();
    xfer(0, 12'h00C, 0, 0);
  endtask
  task automatic scen_prescaled_open;
    boot(8'hBE, 1'b0, 8'h46, 56);
  endtask
  task automatic scen_direct_unlock;
    boot(8'hBD, 1'b0, 8'h3F, 64);
  endtask
  task automatic scen_double_fault;
    boot(8'hBE, 1'b1, 8'h7F, 512);
  endtask
  task automatic scen_backdoor_off;
    boot(8'h7D, 1'b0, 8'h47, 64);
  endtask
  initial begin
    scen_prescaled_open();
    scen_direct_unlock();
    scen_double_fault();
    scen_backdoor_off();
    complete_run();
  end
endmodule
`default_nettype wire
